// ==== logic/system_config_defines.svh ====
// Constants for the system configuration register bank.
// Assumes one bus clock domain and a debug link that tags its own writes.
//
// How it works
// - Force-reset register accepts writes only from background debug commands, never the program.
// - Reading the force-reset register always returns zero.
// - Debug write of 1 to force-reset bit 0 requests a full reset.
// - Options register is always readable; bits 3 and 2 read as zero.
// - Options register takes only the first write after each reset.
// - Watchdog enable bit 7 resets to 1; 1 enables, 0 disables.
// - Timeout select bit 6 resets to 1; 0 gives 2^13, 1 gives 2^18 cycles.
// - Halt permission bit 5 resets to 0; writing 1 permits halt mode.
// - Halt attempt while not permitted forces an illegal-opcode reset, unless a debug force-reset write comes in the same cycle.
// - Pin enable bit 1 set gives debug pin function; clear gives output-only port.
// - Every reset returns the shared pin to its debug function, bit reads 1.
// - Read-only 12-bit part number: high holds bits 11:8, low holds 7:0.
// - Part number is a fixed constant; writes ignored, reset leaves it unchanged.
// - A debug-forced reset records no reset cause in the status register.
`ifndef SYSTEM_CONFIG_DEFINES_SVH
`define SYSTEM_CONFIG_DEFINES_SVH

// ----------------------------------------------------------------
// Register selectors
// ----------------------------------------------------------------
`define SEL_FORCE_RESET 2'h0
`define SEL_OPTIONS 2'h1
`define SEL_PART_HIGH 2'h2
`define SEL_PART_LOW 2'h3

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define FORCE_RESET_BIT 0
`define WDOG_ENABLE_BIT 7
`define WDOG_LONG_BIT 6
`define HALT_ALLOW_BIT 5
`define PIN_ENABLE_BIT 1
`define OPTIONS_RESET 8'hC2
`define OPTIONS_IMPL_MASK 8'hE2
`define READ_ZERO 8'h00
`define PART_HIGH_PAD 4'h0
// Part number value is arbitrary.
`define PART_NUMBER 12'h5A3
`define PART_HIGH_FIELD 11:8
`define PART_LOW_FIELD 7:0

`endif

// ==== logic/system_config_pkg.sv ====
// Types shared by the system configuration register bank.
// Assumes the constants header is included by the design file.
package system_config_pkg;

  // One register access from the processor or the debug link.
  typedef struct packed {
    logic rd;
    logic wr;
    logic from_debug;
    logic [1:0] sel;
    logic [7:0] wdata;
  } reg_req_t;

  // Shared-pin drive produced by the mux.
  typedef struct packed {
    logic level;
    logic oe;
  } pin_drive_t;

endpackage

// ==== logic/system_config_regs.sv ====
// System configuration registers: debug force reset, write-once options,
// and the read-only part number.
// Assumes reg requests arrive on mclk, one per cycle, with from_debug set
// by the background debug link for its own accesses.
`timescale 1ns/100ps
`include "system_config_defines.svh"

module system_config_regs #(
  parameter int unsigned WDOG_SHORT_CYCLES = 8192,
  parameter int unsigned WDOG_LONG_CYCLES = 262144
) (
  input wire logic mclk, // Bus clock, 200 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire system_config_pkg::reg_req_t req, // Register access
  output logic [7:0] rdata, // Read data
  output logic rvalid, // Read data valid pulse
  input wire logic stop_attempt, // Halt instruction executed pulse
  input wire system_config_pkg::pin_drive_t debug_drive, // Debug link drive
  input wire logic port_level, // Port data for output-only use
  input wire logic pin_in, // Shared pin level, asynchronous
  output system_config_pkg::pin_drive_t pin_drive, // Shared pin drive
  output logic debug_pin_level, // Synchronised shared pin level
  output logic watchdog_enable, // Watchdog running
  output logic [18:0] watchdog_period, // Watchdog timeout in cycles
  output logic halt_mode_allow, // Halt mode permitted
  output logic background_pin_enable, // Pin in debug function
  output logic options_locked, // Options already written
  output logic illegal_opcode_reset, // Illegal-opcode reset request pulse
  output logic mcu_reset_req, // Full reset request pulse
  output logic reset_quiet // Reset cause must not be recorded
);
  import system_config_pkg::*;

  // The part number is wired in; neither writes nor reset can reach it.
  localparam logic [11:0] PART_VALUE = `PART_NUMBER;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic wr_force;
  logic wr_options;
  logic rd_any;
  logic [7:0] options;
  logic [7:0] next_options;
  logic [7:0] next_rdata;
  logic [1:0] last_sel;
  logic pin_meta;
  logic force_hit;

  assign wr_force = req.wr && req.from_debug && (req.sel == `SEL_FORCE_RESET);
  assign wr_options = req.wr && (req.sel == `SEL_OPTIONS) && !options_locked;
  assign rd_any = req.rd;
  assign force_hit = wr_force && req.wdata[`FORCE_RESET_BIT];

  // ----------------------------------------------------------------
  // Write-once options
  // ----------------------------------------------------------------
  // Only implemented bits are stored; the rest stay zero so the read
  // path needs no further masking.
  assign next_options = req.wdata & `OPTIONS_IMPL_MASK;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      options <= `OPTIONS_RESET;
    end else if (wr_options) begin
      options <= next_options;
    end
  end

  // The lock is the only guard against stray writes, so it ignores who
  // made the write and only reset can drop it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      options_locked <= 1'b0;
    end else if (wr_options) begin
      options_locked <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Option outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      watchdog_enable <= 1'b1;
      watchdog_period <= 19'(WDOG_LONG_CYCLES);
      halt_mode_allow <= 1'b0;
      background_pin_enable <= 1'b1;
    end else begin
      watchdog_enable <= options[`WDOG_ENABLE_BIT];
      watchdog_period <= options[`WDOG_LONG_BIT] ? 19'(WDOG_LONG_CYCLES) : 19'(WDOG_SHORT_CYCLES);
      halt_mode_allow <= options[`HALT_ALLOW_BIT];
      background_pin_enable <= options[`PIN_ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Reset requests
  // ----------------------------------------------------------------
  // The request lasts one cycle; the reset it causes clears it anyway.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mcu_reset_req <= 1'b0;
      reset_quiet <= 1'b0;
    end else begin
      mcu_reset_req <= force_hit;
      reset_quiet <= force_hit;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      illegal_opcode_reset <= 1'b0;
    end else begin
      // A forced reset in the same cycle wins, so no illegal-opcode cause is left behind.
      illegal_opcode_reset <= stop_attempt && !options[`HALT_ALLOW_BIT] && !force_hit;
    end
  end

  // ----------------------------------------------------------------
  // Shared pin
  // ----------------------------------------------------------------
  // In port use the pin only drives, so the enable is held high.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_drive <= '0;
    end else if (options[`PIN_ENABLE_BIT]) begin
      pin_drive <= debug_drive;
    end else begin
      pin_drive.level <= port_level;
      pin_drive.oe <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_meta <= 1'b0;
      debug_pin_level <= 1'b0;
    end else begin
      pin_meta <= pin_in;
      debug_pin_level <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = `READ_ZERO;
    unique case (req.sel)
      `SEL_FORCE_RESET: next_rdata = `READ_ZERO;
      `SEL_OPTIONS: next_rdata = options;
      `SEL_PART_HIGH: next_rdata = {`PART_HIGH_PAD, PART_VALUE[`PART_HIGH_FIELD]};
      `SEL_PART_LOW: next_rdata = PART_VALUE[`PART_LOW_FIELD];
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= `READ_ZERO;
      rvalid <= 1'b0;
      last_sel <= `SEL_FORCE_RESET;
    end else begin
      rvalid <= rd_any;
      last_sel <= req.sel;
      if (rd_any) begin
        rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_CPU_FORCE_IGNORED: assert property (
    @(posedge mclk) disable iff (rst)
    (req.wr && !req.from_debug && req.sel == `SEL_FORCE_RESET) |=> !mcu_reset_req
  ) else $error("Program write to force-reset register caused a reset.");

  AST_FORCE_READ_ZERO: assert property (
    @(posedge mclk) disable iff (rst)
    (req.rd && req.sel == `SEL_FORCE_RESET) |=> (rvalid && rdata == `READ_ZERO)
  ) else $error("Force-reset register read was not zero.");

  AST_DEBUG_FORCE: assert property (
    @(posedge mclk) disable iff (rst)
    (req.wr && req.from_debug && req.sel == `SEL_FORCE_RESET && req.wdata[`FORCE_RESET_BIT])
      |=> (mcu_reset_req && reset_quiet)
  ) else $error("Debug force-reset write did not give a one-cycle reset.");

  AST_QUIET_ONLY_FORCED: assert property (
    @(posedge mclk) disable iff (rst)
    reset_quiet |-> mcu_reset_req && !illegal_opcode_reset
  ) else $error("Quiet reset flag without a forced reset.");

  AST_OPT_RESERVED: assert property (
    @(posedge mclk) disable iff (rst)
    (rvalid && last_sel == `SEL_OPTIONS) |-> rdata[3:2] == 2'b00
  ) else $error("Options reserved bits read non-zero.");

  AST_WRITE_ONCE: assert property (
    @(posedge mclk) disable iff (rst)
    (options_locked && req.wr && req.sel == `SEL_OPTIONS) |=> $stable(options)
  ) else $error("Options changed after the first write.");

  AST_LOCK_SET: assert property (
    @(posedge mclk) disable iff (rst)
    (req.wr && req.sel == `SEL_OPTIONS) |=> options_locked [*2]
  ) else $error("Options lock not set and held after a write.");

  AST_WDOG_PERIOD: assert property (
    @(posedge mclk) disable iff (rst)
    ##1 (watchdog_period == ($past(options[`WDOG_LONG_BIT]) ? 19'(WDOG_LONG_CYCLES) : 19'(WDOG_SHORT_CYCLES)))
  ) else $error("Watchdog period does not follow the select bit.");

  AST_ILLEGAL_HALT: assert property (
    @(posedge mclk) disable iff (rst)
    stop_attempt |=> (illegal_opcode_reset == (!halt_mode_allow && !mcu_reset_req))
  ) else $error("Halt attempt handled against the permission bit.");

  AST_PORT_PIN: assert property (
    @(posedge mclk) disable iff (rst)
    !options[`PIN_ENABLE_BIT] |=> (pin_drive.oe && pin_drive.level == $past(port_level))
  ) else $error("Port function not driving the shared pin.");

  AST_PART_NUMBER: assert property (
    @(posedge mclk) disable iff (rst)
    (req.rd && req.sel == `SEL_PART_LOW) ##1 (req.rd && req.sel == `SEL_PART_HIGH)
      |=> rdata == {`PART_HIGH_PAD, PART_VALUE[`PART_HIGH_FIELD]} && $past(rdata) == PART_VALUE[`PART_LOW_FIELD]
  ) else $error("Part number read back wrong.");

  // ----------------------------------------------------------------
  // Checks on pulses, lock and derived outputs
  // ----------------------------------------------------------------
  AST_FORCE_PULSE: assert property (
    @(posedge mclk) disable iff (rst)
    mcu_reset_req
      |-> $past(req.wr && req.from_debug && req.sel == `SEL_FORCE_RESET && req.wdata[`FORCE_RESET_BIT])
  ) else $error("Reset request without a debug write of one.");

  AST_FORCE_ZERO: assert property (
    @(posedge mclk) disable iff (rst)
    (req.wr && req.from_debug && req.sel == `SEL_FORCE_RESET && !req.wdata[`FORCE_RESET_BIT])
      |=> !mcu_reset_req
  ) else $error("Debug write of zero to the force-reset bit caused a reset.");

  AST_QUIET_WITH_FORCE: assert property (
    @(posedge mclk) disable iff (rst)
    mcu_reset_req |-> reset_quiet
  ) else $error("Forced reset without the quiet flag.");

  AST_LOCK_HOLDS: assert property (
    @(posedge mclk) disable iff (rst)
    options_locked |=> options_locked
  ) else $error("Options lock dropped without a reset.");

  AST_LOCK_NEEDS_WRITE: assert property (
    @(posedge mclk) disable iff (rst)
    (!options_locked && !(req.wr && req.sel == `SEL_OPTIONS)) |=> !options_locked
  ) else $error("Options lock set without a write.");

  AST_FIRST_WRITE: assert property (
    @(posedge mclk) disable iff (rst)
    (!options_locked && req.wr && req.sel == `SEL_OPTIONS)
      |=> (options == ($past(req.wdata) & `OPTIONS_IMPL_MASK))
  ) else $error("First options write not taken.");

  AST_OPT_UNIMPL: assert property (
    @(posedge mclk) disable iff (rst)
    (options & ~`OPTIONS_IMPL_MASK) == `READ_ZERO
  ) else $error("Unimplemented options bits hold a one.");

  AST_WDOG_ENABLE: assert property (
    @(posedge mclk) disable iff (rst)
    1'b1 |=> (watchdog_enable == $past(options[`WDOG_ENABLE_BIT]))
  ) else $error("Watchdog enable does not follow its bit.");

  AST_HALT_FOLLOWS: assert property (
    @(posedge mclk) disable iff (rst)
    1'b1 |=> (halt_mode_allow == $past(options[`HALT_ALLOW_BIT]))
  ) else $error("Halt permission does not follow its bit.");

  AST_PIN_ENABLE_FOLLOWS: assert property (
    @(posedge mclk) disable iff (rst)
    1'b1 |=> (background_pin_enable == $past(options[`PIN_ENABLE_BIT]))
  ) else $error("Pin enable does not follow its bit.");

  AST_DEBUG_PIN: assert property (
    @(posedge mclk) disable iff (rst)
    options[`PIN_ENABLE_BIT] |=> (pin_drive == $past(debug_drive))
  ) else $error("Debug function not passing the link drive to the pin.");

  AST_PART_HIGH: assert property (
    @(posedge mclk) disable iff (rst)
    (req.rd && req.sel == `SEL_PART_HIGH) |=> (rdata == {`PART_HIGH_PAD, PART_VALUE[`PART_HIGH_FIELD]})
  ) else $error("Part number high read wrong.");

  AST_PART_LOW: assert property (
    @(posedge mclk) disable iff (rst)
    (req.rd && req.sel == `SEL_PART_LOW) |=> (rdata == PART_VALUE[`PART_LOW_FIELD])
  ) else $error("Part number low read wrong.");

  AST_RVALID_PULSE: assert property (
    @(posedge mclk) disable iff (rst)
    rvalid |-> $past(req.rd)
  ) else $error("Read valid without a read request.");

endmodule // system_config_regs

// ==== verif/debug_host_model.sv ====
// Model of the external debug host that issues background commands.
// Assumes the bench merges host_req onto the register access port.
`timescale 1ns/100ps
module debug_host_model (
  input wire logic mclk, // Bus clock
  output system_config_pkg::reg_req_t host_req, // Background command access
  output system_config_pkg::pin_drive_t debug_drive // Host side of the shared pin
);
  import system_config_pkg::*;
  logic [7:0] pat = 8'h00;
  initial host_req = '0;
  initial debug_drive = '0;
  // The pin drive changes every cycle, so a stale value never looks like a match.
  always @(posedge mclk) begin
    pat <= pat + 8'h01;
    debug_drive <= '{level: pat[0], oe: pat[1]};
  end
  // One background command, held for exactly one sampling edge.
  task automatic command(input logic rd, input logic [1:0] sel, input logic [7:0] data);
    @(posedge mclk);
    host_req <= '{rd: rd, wr: !rd, from_debug: 1'b1, sel: sel, wdata: data};
    @(posedge mclk);
    host_req <= '0;
  endtask
endmodule // debug_host_model

// ==== verif/tb_system_config_regs.sv ====
// Self-checking bench for the system configuration registers.
// Assumes the debug host model shares the access port with the program.
`timescale 1ns/100ps
module tb_system_config_regs;
  import system_config_pkg::*;
  localparam int SHORT = 8;
  localparam int LONG = 64;
  logic mclk = 0, rst = 1, stop_attempt = 0, port_level = 0, pin_in = 0;
  reg_req_t prog_req = '0, host_req, req;
  pin_drive_t debug_drive, pin_drive;
  logic [7:0] rdata, w;
  logic [18:0] watchdog_period;
  logic rvalid, debug_pin_level, watchdog_enable, halt_mode_allow, background_pin_enable;
  logic options_locked, illegal_opcode_reset, mcu_reset_req, reset_quiet;
  int num_errors = 0, samples_checked = 0, opt = 8'hC2, locked = 0;
  assign req = (host_req.rd | host_req.wr) ? host_req : prog_req;
  system_config_regs #(.WDOG_SHORT_CYCLES(SHORT), .WDOG_LONG_CYCLES(LONG)) i_system_config_regs (
    .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .stop_attempt(stop_attempt),
    .debug_drive(debug_drive), .port_level(port_level), .pin_in(pin_in), .pin_drive(pin_drive),
    .debug_pin_level(debug_pin_level), .watchdog_enable(watchdog_enable), .watchdog_period(watchdog_period),
    .halt_mode_allow(halt_mode_allow), .background_pin_enable(background_pin_enable),
    .options_locked(options_locked), .illegal_opcode_reset(illegal_opcode_reset),
    .mcu_reset_req(mcu_reset_req), .reset_quiet(reset_quiet));
  debug_host_model i_debug_host_model (.mclk(mclk), .host_req(host_req), .debug_drive(debug_drive));
  initial forever #2.5 mclk = ~mclk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic access(input logic rd, input logic [1:0] sel, input logic [7:0] data);
    @(posedge mclk);
    prog_req <= '{rd: rd, wr: !rd, from_debug: 1'b0, sel: sel, wdata: data};
    @(posedge mclk);
    prog_req <= '0;
    #1;
  endtask
  task automatic rd_check(input logic [1:0] sel, input int exp);
    access(1'b1, sel, 8'h00);
    check("rvalid", rvalid, 1);
    check("rdata", rdata, exp);
  endtask
  // Reference model of the write-once options register.
  task automatic model_wr(input logic [7:0] d);
    if (locked == 0) opt = d & 8'hE2;
    locked = 1;
  endtask
  task automatic stop_pulse();
    @(posedge mclk);
    stop_attempt <= 1'b1;
    @(posedge mclk);
    stop_attempt <= 1'b0;
    #1;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    w = 8'($urandom(28));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check("wdog_en", watchdog_enable, 1);
    check("period", watchdog_period, LONG);
    check("halt", halt_mode_allow, 0);
    check("background_pin", background_pin_enable, 1);
    rd_check(2'h1, opt);
    rd_check(2'h2, 8'h05);
    rd_check(2'h3, 8'hA3);
    // Low then high on consecutive edges, so the pair is read as one number.
    @(posedge mclk);
    prog_req <= '{rd: 1'b1, wr: 1'b0, from_debug: 1'b0, sel: 2'h3, wdata: 8'h00};
    @(posedge mclk);
    prog_req <= '{rd: 1'b1, wr: 1'b0, from_debug: 1'b0, sel: 2'h2, wdata: 8'h00};
    #1;
    check("rdata_lo", rdata, 8'hA3);
    @(posedge mclk);
    prog_req <= '0;
    #1;
    check("rdata_hi", rdata, 8'h05);
    access(1'b0, 2'h2, 8'hFF);
    access(1'b0, 2'h3, 8'h00);
    rd_check(2'h2, 8'h05);
    rd_check(2'h3, 8'hA3);
    access(1'b0, 2'h0, 8'h01);
    check("force", mcu_reset_req, 0);
    rd_check(2'h0, 8'h00);
    i_debug_host_model.command(1'b0, 2'h0, 8'h01);
    #1;
    check("force", mcu_reset_req, 1);
    check("quiet", reset_quiet, 1);
    @(posedge mclk);
    #1;
    check("force", mcu_reset_req, 0);
    i_debug_host_model.command(1'b0, 2'h0, 8'hFE);
    #1;
    check("force", mcu_reset_req, 0);
    for (int k = 0; k < 3; k++) begin
      w = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom());
      @(posedge mclk);
      port_level <= w[0];
      pin_in <= w[2];
      if (k == 2) i_debug_host_model.command(1'b0, 2'h1, w);
      else access(1'b0, 2'h1, w);
      model_wr(w);
      access(1'b0, 2'h1, ~w);
      model_wr(~w);
      rd_check(2'h1, opt);
      check("locked", options_locked, 1);
      check("wdog_en", watchdog_enable, opt[7]);
      check("period", watchdog_period, opt[6] ? LONG : SHORT);
      check("halt", halt_mode_allow, opt[5]);
      check("background_pin", background_pin_enable, opt[1]);
      if (!opt[1]) check("pin", pin_drive, {port_level, 1'b1});
      check("pin_sync", debug_pin_level, w[2]);
      stop_pulse();
      check("illegal_opcode_reset_flag", illegal_opcode_reset, !opt[5]);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      opt = 8'hC2;
      locked = 0;
      rd_check(2'h1, opt);
      check("locked", options_locked, 0);
    end
    report_and_stop();
  end
endmodule // tb_system_config_regs
